// [pkg/sas_regs.svh]
/*
  Register offsets, field positions, reset values and counts of the converter sequencer.
  Assumes byte addressing on a 32-bit Avalon-MM slave, one register per aligned word.
*/
// Notes on behaviour
// - Three modes: single conversion, one scan pass, continuous scanning.
// - Single mode converts the selected channel once, then stops.
// - Scan pass converts enabled channels once, lowest to highest number.
// - Continuous mode repeats scan passes until software clears the start bit.
// - Writing one to control bit 11 starts a conversion sequence.
// - Either pulse generator trigger or external start pin also starts a sequence.
// - One result register per channel with valid and overrun flags.
// - Two independent comparators check results against programmed values.
// - Each comparator match may be chosen to raise an interrupt.
// - Channel 7 selects external input or internal band-gap reference.
// - Eight single-ended channels or four differential pairs, as configured.
// - Each result is stored as a 12-bit unsigned value.
`ifndef SAS_REGS_SVH
`define SAS_REGS_SVH

`define SAS_CTRL_OFS 8'h00
`define SAS_CHEN_OFS 8'h04
`define SAS_CMP0_OFS 8'h08
`define SAS_CMP1_OFS 8'h0C
`define SAS_STAT_OFS 8'h10
`define SAS_RES_OFS 8'h20

`define SAS_CTRL_MODE_LSB 0
`define SAS_CTRL_DIFF_BIT 4
`define SAS_CTRL_BGAP_BIT 5
`define SAS_CTRL_PWMEN_BIT 6
`define SAS_CTRL_EXTEN_BIT 7
`define SAS_CTRL_SEL_LSB 8
`define SAS_CTRL_START_BIT 11

`define SAS_CMP_VAL_LSB 0
`define SAS_CMP_CH_LSB 12
`define SAS_CMP_EN_BIT 16
`define SAS_CMP_IRQEN_BIT 17
`define SAS_CMP_GEQ_BIT 18

`define SAS_STAT_BUSY_BIT 0
`define SAS_STAT_FLAG_LSB 1
`define SAS_STAT_CUR_LSB 8

`define SAS_RES_VALID_BIT 16
`define SAS_RES_OVR_BIT 17

`define SAS_CHEN_RST 8'hFF
`define SAS_DIFF_MASK 8'h0F
`define SAS_NUM_CH 8
`define SAS_RES_BITS 12

`endif

// [pkg/sas_pkg.sv]
/*
  Types shared by the converter sequencer files.
  Assumes the constants header is compiled alongside.
*/
package sas_pkg;

  typedef enum logic [1:0] {
    SAS_MODE_SINGLE,
    SAS_MODE_PASS,
    SAS_MODE_CONT,
    SAS_MODE_RSVD
  } sas_mode_t;

  typedef enum logic [1:0] {
    SAS_IDLE,
    SAS_ISSUE,
    SAS_WAIT
  } sas_state_t;

endpackage : sas_pkg

// [logic/sas_buf2.sv]
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none
module sas_buf2 #(
  parameter int W = 15
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [W-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [W-1:0] outData
);

  if (W < 1) begin : gChk
    $error("sas_buf2 width must be positive");
  end

  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic [1:0] cnt;
    logic rdPtr;
    logic wrPtr;
    logic ready;
  } sas_buf_t;

  sas_buf_t s_q, s_d;
  logic doPush, doPop;

  always_comb begin
    s_d = s_q;
    doPush = inValid && s_q.ready;
    doPop = (s_q.cnt != 2'h0) && outReady;
    if (doPush) begin
      s_d.mem[s_q.wrPtr] = inData;
      s_d.wrPtr = ~s_q.wrPtr;
    end
    if (doPop) begin
      s_d.rdPtr = ~s_q.rdPtr;
    end
    s_d.cnt = s_q.cnt + {1'b0, doPush} - {1'b0, doPop};
    s_d.ready = (s_d.cnt != 2'h2);
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.ready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign inReady = s_q.ready;
  assign outValid = (s_q.cnt != 2'h0);
  assign outData = s_q.mem[s_q.rdPtr];

endmodule : sas_buf2
`default_nettype wire

// [logic/sas_sequencer.sv]
/*
  Sequencer, result store and comparators of a 12-bit successive-approximation converter,
  with an Avalon-MM register slave.
  Assumes an analogue core that answers each start pulse with one done pulse and result,
  and trigger inputs synchronous to the clock.
*/
// The implementer's own choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "sas_regs.svh"
module sas_sequencer
  import sas_pkg::*;
#(
  parameter int NCH = `SAS_NUM_CH,
  parameter int RW = `SAS_RES_BITS
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic [1:0] basicPulseGeneratorTrigger,
  input wire logic externalStartPin,
  output logic convStart,
  output logic [2:0] convChannel,
  output logic convDiff,
  output logic convBandgap,
  input wire logic convDone,
  input wire logic [RW-1:0] convResult,
  output logic convResultReady,
  output logic busy,
  output logic [1:0] cmpIrq
);

  if (NCH != `SAS_NUM_CH || RW != `SAS_RES_BITS) begin : gChk
    $error("sas_sequencer supports 8 channels of 12-bit results only");
  end

  typedef struct packed {
    logic waitReq;
    logic [31:0] rdata;
    sas_mode_t mode;
    logic diff;
    logic bgSel;
    logic pwmEn;
    logic extEn;
    logic [2:0] selCh;
    logic start;
    logic [7:0] chEn;
    logic [1:0][18:0] cmpCfg;
    logic [1:0] cmpFlag;
    logic [1:0] cmpIrq;
    sas_state_t st;
    logic [2:0] cur;
    logic convStart;
    logic extPrev;
    logic [NCH-1:0][RW+1:0] res;
    logic busyOut;
    logic bgOut;
  } sas_state_all_t;

  sas_state_all_t s_q, s_d;

  logic bufOutValid, bufOutReady;
  logic [RW+2:0] bufOutData;
  logic [NCH-1:0] resHit;
  logic [3:0] found;
  logic [7:0] effEn;
  logic [2:0] dCh;
  logic [RW-1:0] dRes;
  logic [11:0] cVal;
  logic match;
  logic effect;
  logic [31:0] wmask;
  logic [31:0] merged;

  // Per-channel result address decode
  for (genvar i = 0; i < NCH; i++) begin : gHit
    assign resHit[i] = (address == 8'(`SAS_RES_OFS + 4 * i));
  end

  // Lowest enabled channel at or above a start point; bit 3 flags a find
  function automatic logic [3:0] firstFrom(input logic [7:0] m, input logic [3:0] from);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 7; i >= 0; i--) begin
      if (m[i] && (4'(i) >= from)) begin
        r = {1'b1, 3'(i)};
      end
    end
    return r;
  endfunction : firstFrom

  function automatic logic [31:0] regValue(input sas_state_all_t s, input logic [7:0] a,
                                           input logic [NCH-1:0] hit);
    logic [31:0] v;
    v = 32'h0;
    case (a)
      `SAS_CTRL_OFS: begin
        v[`SAS_CTRL_MODE_LSB +: 2] = s.mode;
        v[`SAS_CTRL_DIFF_BIT] = s.diff;
        v[`SAS_CTRL_BGAP_BIT] = s.bgSel;
        v[`SAS_CTRL_PWMEN_BIT] = s.pwmEn;
        v[`SAS_CTRL_EXTEN_BIT] = s.extEn;
        v[`SAS_CTRL_SEL_LSB +: 3] = s.selCh;
        v[`SAS_CTRL_START_BIT] = s.start;
      end
      `SAS_CHEN_OFS: v[7:0] = s.chEn;
      `SAS_CMP0_OFS: v[18:0] = s.cmpCfg[0];
      `SAS_CMP1_OFS: v[18:0] = s.cmpCfg[1];
      `SAS_STAT_OFS: begin
        v[`SAS_STAT_BUSY_BIT] = (s.st != SAS_IDLE);
        v[`SAS_STAT_FLAG_LSB +: 2] = s.cmpFlag;
        v[`SAS_STAT_CUR_LSB +: 3] = s.cur;
      end
      default: begin
        for (int i = 0; i < NCH; i++) begin
          if (hit[i]) begin
            v[RW-1:0] = s.res[i][RW-1:0];
            v[`SAS_RES_VALID_BIT] = s.res[i][RW];
            v[`SAS_RES_OVR_BIT] = s.res[i][RW+1];
          end
        end
      end
    endcase
    return v;
  endfunction : regValue

  // Results wait here while the bus reads a result word
  sas_buf2 #(
    .W(RW + 3)
  ) uBuf (
    .clock(clock),
    .nrst(nrst),
    .inValid(convDone),
    .inReady(convResultReady),
    .inData({s_q.cur, convResult}),
    .outValid(bufOutValid),
    .outReady(bufOutReady),
    .outData(bufOutData)
  );

  assign bufOutReady = !(read && (resHit != '0));

  always_comb begin
    s_d = s_q;
    s_d.convStart = 1'b0;
    s_d.extPrev = externalStartPin;
    effect = 1'b0;
    wmask = 32'h0;
    merged = 32'h0;
    effEn = s_q.chEn & (s_q.diff ? `SAS_DIFF_MASK : 8'hFF);
    found = 4'h0;
    dCh = bufOutData[RW+2:RW];
    dRes = bufOutData[RW-1:0];
    cVal = 12'h0;
    match = 1'b0;

    case (s_q.st)
      SAS_IDLE: begin
        if (s_q.start) begin
          if (s_q.mode == SAS_MODE_SINGLE) begin
            s_d.cur = s_q.diff ? {1'b0, s_q.selCh[1:0]} : s_q.selCh;
            s_d.st = SAS_ISSUE;
          end else begin
            found = firstFrom(effEn, 4'h0);
            if (found[3]) begin
              s_d.cur = found[2:0];
              s_d.st = SAS_ISSUE;
            end else begin
              s_d.start = 1'b0;
            end
          end
        end
      end
      SAS_ISSUE: begin
        if (convResultReady) begin
          s_d.convStart = 1'b1;
          s_d.st = SAS_WAIT;
        end
      end
      SAS_WAIT: begin
        if (convDone) begin
          found = firstFrom(effEn, {1'b0, s_q.cur} + 4'h1);
          if (s_q.mode == SAS_MODE_SINGLE) begin
            s_d.start = 1'b0;
            s_d.st = SAS_IDLE;
          end else if (found[3]) begin
            s_d.cur = found[2:0];
            s_d.st = SAS_ISSUE;
          end else if (s_q.mode == SAS_MODE_CONT && s_q.start) begin
            found = firstFrom(effEn, 4'h0);
            s_d.cur = found[2:0];
            s_d.st = found[3] ? SAS_ISSUE : SAS_IDLE;
            s_d.start = found[3];
          end else begin
            s_d.start = 1'b0;
            s_d.st = SAS_IDLE;
          end
        end
      end
      default: s_d.st = SAS_IDLE;
    endcase

    // Hardware start sources; a trigger on the closing cycle wins
    if (s_q.pwmEn && (basicPulseGeneratorTrigger != 2'h0)) begin
      s_d.start = 1'b1;
    end
    if (s_q.extEn && externalStartPin && !s_q.extPrev) begin
      s_d.start = 1'b1;
    end

    // Result store and comparators
    if (bufOutValid && bufOutReady) begin
      s_d.res[dCh][RW+1] = s_q.res[dCh][RW+1] | s_q.res[dCh][RW];
      s_d.res[dCh][RW] = 1'b1;
      s_d.res[dCh][RW-1:0] = dRes;
      for (int k = 0; k < 2; k++) begin
        cVal = s_q.cmpCfg[k][`SAS_CMP_VAL_LSB +: 12];
        match = s_q.cmpCfg[k][`SAS_CMP_GEQ_BIT] ? (dRes >= cVal) : (dRes < cVal);
        if (s_q.cmpCfg[k][`SAS_CMP_EN_BIT] && match &&
            (s_q.cmpCfg[k][`SAS_CMP_CH_LSB +: 3] == dCh)) begin
          s_d.cmpFlag[k] = 1'b1;
        end
      end
    end

    // Bus slave: answer one cycle after the request, effects on the answer edge
    if (s_q.waitReq) begin
      if (read || write) begin
        s_d.waitReq = 1'b0;
        s_d.rdata = read ? regValue(s_q, address, resHit) : 32'h0;
      end
    end else begin
      s_d.waitReq = 1'b1;
      effect = 1'b1;
    end

    if (effect && read) begin
      for (int i = 0; i < NCH; i++) begin
        if (resHit[i]) begin
          s_d.res[i][RW+1:RW] = 2'b00;
        end
      end
    end

    if (effect && write) begin
      for (int b = 0; b < 4; b++) begin
        wmask[8*b +: 8] = {8{byteenable[b]}};
      end
      merged = (regValue(s_q, address, resHit) & ~wmask) | (writedata & wmask);
      case (address)
        `SAS_CTRL_OFS: begin
          s_d.mode = sas_mode_t'(merged[`SAS_CTRL_MODE_LSB +: 2]);
          s_d.diff = merged[`SAS_CTRL_DIFF_BIT];
          s_d.bgSel = merged[`SAS_CTRL_BGAP_BIT];
          s_d.pwmEn = merged[`SAS_CTRL_PWMEN_BIT];
          s_d.extEn = merged[`SAS_CTRL_EXTEN_BIT];
          s_d.selCh = merged[`SAS_CTRL_SEL_LSB +: 3];
          s_d.start = merged[`SAS_CTRL_START_BIT];
        end
        `SAS_CHEN_OFS: s_d.chEn = merged[7:0];
        `SAS_CMP0_OFS: s_d.cmpCfg[0] = merged[18:0];
        `SAS_CMP1_OFS: s_d.cmpCfg[1] = merged[18:0];
        `SAS_STAT_OFS: begin
          // Write one clears; a match in the same cycle that newly sets the flag keeps it
          for (int k = 0; k < 2; k++) begin
            if (writedata[`SAS_STAT_FLAG_LSB + k] && byteenable[0] &&
                !(s_d.cmpFlag[k] && !s_q.cmpFlag[k])) begin
              s_d.cmpFlag[k] = 1'b0;
            end
          end
        end
        default: ;
      endcase
    end

    for (int k = 0; k < 2; k++) begin
      s_d.cmpIrq[k] = s_d.cmpFlag[k] & s_d.cmpCfg[k][`SAS_CMP_IRQEN_BIT];
    end
    s_d.busyOut = (s_d.st != SAS_IDLE);
    s_d.bgOut = s_d.bgSel && (s_d.cur == 3'h7);
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.waitReq <= 1'b1;
      s_q.chEn <= `SAS_CHEN_RST;
      s_q.st <= SAS_IDLE;
      s_q.mode <= SAS_MODE_SINGLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign readdata = s_q.rdata;
  assign waitrequest = s_q.waitReq;
  assign convStart = s_q.convStart;
  assign convChannel = s_q.cur;
  assign convDiff = s_q.diff;
  assign convBandgap = s_q.bgOut;
  assign busy = s_q.busyOut;
  assign cmpIrq = s_q.cmpIrq;

endmodule : sas_sequencer
`default_nettype wire

// [bench/sas_sequencer_chk.sv]
/*
  Port checker for the converter sequencer, bound to its top module.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none
module sas_sequencer_chk (
  input wire logic clock,
  input wire logic nrst,
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  input wire logic convStart,
  input wire logic [2:0] convChannel,
  input wire logic convDiff,
  input wire logic convBandgap,
  input wire logic convDone,
  input wire logic convResultReady,
  input wire logic busy
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  logic pend_q;
  // Conversion outstanding at the core
  always_ff @(posedge clock) begin
    if (!nrst) pend_q <= 1'b0;
    else if (convStart) pend_q <= 1'b1;
    else if (convDone) pend_q <= 1'b0;
  end
  sequence accTaken;
    (read || write) && waitrequest;
  endsequence
  sequence accAnswer;
    !waitrequest ##1 waitrequest;
  endsequence
  acc_wait_a: assert property (accTaken |=> accAnswer) else $error("bus answer late");
  wait_cause_a: assert property ($fell(waitrequest) |-> $past(read || write))
    else $error("answer without request");
  start_pulse_a: assert property (convStart |=> !convStart) else $error("start too long");
  ready_gate_a: assert property (convStart |-> $past(convResultReady))
    else $error("start without room");
  one_out_a: assert property (pend_q |-> !convStart) else $error("second start");
  done_gap_a: assert property (convDone |=> !convStart) else $error("start after done");
  chan_hold_a: assert property (pend_q |-> $stable(convChannel)) else $error("channel moved");
  bg_sel_a: assert property (convBandgap |-> convChannel == 3'h7) else $error("bad band-gap");
  diff_ch_a: assert property (convStart && convDiff |-> !convChannel[2])
    else $error("bad pair");
  busy_run_a: assert property (convStart |-> busy) else $error("not busy");
endmodule : sas_sequencer_chk
bind sas_sequencer sas_sequencer_chk chk_u (.clock(clock), .nrst(nrst), .read(read),
  .write(write), .waitrequest(waitrequest), .convStart(convStart), .convChannel(convChannel),
  .convDiff(convDiff), .convBandgap(convBandgap), .convDone(convDone),
  .convResultReady(convResultReady), .busy(busy));
`default_nettype wire

// [bench/sas_core_model.sv]
/*
  Model of the analogue converter core.
  Assumes one start pulse per conversion; lat sets the extra delay.
*/
`timescale 1ns/10ps
`default_nettype none
module sas_core_model (
  input wire logic clock,
  input wire logic nrst,
  input wire logic convStart,
  input wire logic [2:0] convChannel,
  input wire logic convBandgap,
  input wire logic convResultReady,
  input wire logic [3:0] lat,
  output logic convDone,
  output logic [11:0] convResult
);
  logic pend;
  logic [3:0] cnt;
  logic [11:0] last;
  // Result only valid with done, inverse otherwise
  assign convResult = convDone ? last : ~last;
  always @(posedge clock) begin
    convDone <= 1'b0;
    if (!nrst) begin
      pend <= 1'b0;
      last <= 12'h000;
    end else if (convStart) begin
      pend <= 1'b1;
      cnt <= lat;
    end else if (pend && cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end else if (pend && convResultReady) begin
      pend <= 1'b0;
      convDone <= 1'b1;
      last <= {4'hA, 3'h0, convBandgap, 1'b0, convChannel};
    end
  end
endmodule : sas_core_model
`default_nettype wire

// [bench/test_sas_sequencer.sv]
/*
  Self-checking bench of the converter sequencer.
  Assumes the core model and the bound checker.
*/
`timescale 1ns/10ps
`default_nettype none
`include "sas_regs.svh"
module test_sas_sequencer;
  logic clock, nrst, read, write, waitrequest, convStart, convDiff, convBandgap;
  logic convDone, convResultReady, busy, externalStartPin;
  logic [7:0] address;
  logic [31:0] writedata, readdata, q;
  logic [1:0] trig, cmpIrq;
  logic [2:0] convChannel;
  logic [11:0] convResult;
  logic [3:0] lat;
  logic [2:0] chq[$];
  int num_errors, num_checks, starts;
  sas_sequencer dut_u (.clock(clock), .nrst(nrst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
    .waitrequest(waitrequest), .basicPulseGeneratorTrigger(trig),
    .externalStartPin(externalStartPin), .convStart(convStart), .convChannel(convChannel),
    .convDiff(convDiff), .convBandgap(convBandgap), .convDone(convDone),
    .convResult(convResult), .convResultReady(convResultReady), .busy(busy),
    .cmpIrq(cmpIrq));
  sas_core_model core_u (.clock(clock), .nrst(nrst), .convStart(convStart),
    .convChannel(convChannel), .convBandgap(convBandgap), .convResultReady(convResultReady),
    .lat(lat), .convDone(convDone), .convResult(convResult));
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock) begin
    if (convStart === 1'b1) begin
      starts++;
      chq.push_back(convChannel);
    end
  end
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  function automatic logic [31:0] res(input logic [2:0] ch, input logic bg);
    return {20'h0, 4'hA, 3'h0, bg, 1'b0, ch};
  endfunction : res
  // One Avalon access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    address <= a;
    writedata <= d;
    read <= ~w;
    write <= w;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 50) begin
      num_errors++;
      print_verdict();
    end
  endtask : bus
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask : rdc
  // Poll until the start bit and busy both drop, then let the result land
  task automatic idle();
    int n;
    n = 0;
    do begin
      bus(1'b0, `SAS_CTRL_OFS, 32'h0);
      n++;
    end while ((q[11] !== 1'b0 || busy !== 1'b0) && n < 200);
    if (n >= 200) begin
      num_errors++;
      print_verdict();
    end
    repeat (3) @(posedge clock);
  endtask : idle
  task automatic run(input logic [31:0] c);
    bus(1'b1, `SAS_CTRL_OFS, c);
    idle();
  endtask : run
  task automatic t_single();
    int s;
    s = starts;
    run(32'h00000D00);
    chk("starts", s + 1, starts);
    chk("chan", 32'h5, chq[$]);
    rdc(8'h34, res(3'h5, 1'b0) | 32'h00010000, "res5");
    rdc(8'h34, res(3'h5, 1'b0), "res5 again");
    rdc(8'h80, 32'h0, "unmapped");
    run(32'h00000F10);
    chk("diff chan", 32'h3, chq[$]);
  endtask : t_single
  task automatic t_over();
    run(32'h00000A00);
    run(32'h00000A00);
    rdc(8'h28, res(3'h2, 1'b0) | 32'h00030000, "res2 ovr");
    rdc(8'h28, res(3'h2, 1'b0), "res2 clr");
  endtask : t_over
  task automatic t_scan(input logic [31:0] en, input logic [31:0] c, input int k);
    bus(1'b1, `SAS_CHEN_OFS, en);
    chq.delete();
    run(c);
    chk("count", k, chq.size());
  endtask : t_scan
  task automatic t_cont();
    int n;
    bus(1'b1, `SAS_CHEN_OFS, 32'h3);
    chq.delete();
    bus(1'b1, `SAS_CTRL_OFS, 32'h00000802);
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (chq.size() < 5 && n < 500);
    if (n >= 500) begin
      num_errors++;
      print_verdict();
    end
    bus(1'b1, `SAS_CTRL_OFS, 32'h0);
    idle();
    chk("cont runs", 32'h1, chq.size() >= 5);
    for (int i = 0; i < chq.size(); i++) chk("cont chan", i % 2, chq[i]);
  endtask : t_cont
  task automatic t_trig();
    int s;
    s = starts;
    bus(1'b1, `SAS_CTRL_OFS, 32'h00000140);
    trig <= 2'b10;
    @(posedge clock);
    trig <= 2'b00;
    idle();
    chk("pulse start", s + 1, starts);
    bus(1'b1, `SAS_CTRL_OFS, 32'h00000280);
    externalStartPin <= 1'b1;
    idle();
    externalStartPin <= 1'b0;
    chk("pin start", s + 2, starts);
    chk("pin chan", 32'h2, chq[$]);
  endtask : t_trig
  task automatic t_cmp();
    bus(1'b1, `SAS_CMP0_OFS, 32'h00073100);
    bus(1'b1, `SAS_CMP1_OFS, 32'h00053100);
    run(32'h00000B00);
    chk("irq", 32'h1, cmpIrq);
    bus(1'b0, `SAS_STAT_OFS, 32'h0);
    chk("flags", 32'h3, q[2:1]);
    bus(1'b1, `SAS_STAT_OFS, 32'h6);
    repeat (2) @(posedge clock);
    chk("irq clr", 32'h0, cmpIrq);
  endtask : t_cmp
  initial begin
    nrst = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 8'h00;
    writedata = 32'h0;
    trig = 2'b00;
    externalStartPin = 1'b0;
    lat = 4'h0;
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    rdc(`SAS_CHEN_OFS, 32'h000000FF, "chen");
    t_single();
    t_over();
    t_scan(32'h29, 32'h00000801, 3);
    chk("order", 32'h035, {chq[0], 1'b0, chq[1], 1'b0, chq[2]});
    t_scan(32'hFF, 32'h00000811, 4);
    t_cont();
    t_trig();
    lat <= 4'h9;
    run(32'h00000F20);
    rdc(8'h3C, res(3'h7, 1'b1) | 32'h00010000, "bgap");
    t_cmp();
    print_verdict();
  end
endmodule : test_sas_sequencer
`default_nettype wire
